// [common/apkt_pkg.sv]
// constants, offsets and carrier types of the packet channel handler
package apkt_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [8:0] IDX_CTRL = 9'h0E2;
  localparam logic [8:0] IDX_STAT = 9'h0E3;
  localparam logic [8:0] IDX_NODE_HI = 9'h0E4;
  localparam logic [8:0] IDX_NODE_LO = 9'h0E5;
  localparam logic [8:0] IDX_BW = 9'h0E6;
  localparam logic [8:0] IDX_ALT_HI = 9'h0E8;
  localparam logic [8:0] IDX_ALT_LO = 9'h0E9;
  localparam logic [8:0] IDX_START = 9'h0EA;
  localparam logic [8:0] IDX_LEN = 9'h0EC;
  localparam logic [8:0] IDX_PRIO = 9'h0F2;
  localparam logic [8:0] IDX_RXBUF = 9'h180;
  localparam logic [8:0] IDX_TXBUF = 9'h1C0;
  // ----------------------------------------------------------------
  // buffer sizes, fields, limits
  // ----------------------------------------------------------------
  localparam int RX_BYTES = 52;
  localparam int TX_BYTES = 50;
  localparam logic [7:0] LEN_MIN = 8'h01;
  localparam logic [7:0] LEN_MAX = 8'h0D;
  localparam int B_RX_RELEASE_CMD = 0;
  localparam int B_TX_DONE_CLEAR_CMD = 1;
  localparam int B_RAC = 3;
  localparam int B_RAF = 4;
  localparam int B_TX_START_CMD = 7;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ALT_HI = 8'h00;
  localparam logic [7:0] RST_ALT_LO = 8'h0F;
  localparam logic [7:0] RST_NODE_HI = 8'h00;
  localparam logic [7:0] RST_NODE_LO = 8'h00;
  localparam logic [7:0] RST_BW = 8'h00;
  localparam logic [7:0] RST_PRIO = 8'h01;
  localparam logic [7:0] RST_TGT_HI = 8'h0F;
  localparam logic [7:0] RST_TGT_LO = 8'hFF;
  // ----------------------------------------------------------------
  // link carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic crc_ok;
    logic [7:0] data;
  } rx_beat_t;
  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic [7:0] data;
  } tx_beat_t;
  typedef enum logic [1:0] {TX_IDLE, TX_ARB, TX_SEND} tx_state_t;
endpackage : apkt_pkg

// [rtl/async_packet_channel_handler.sv]
// packet channel: register slave, rx validation, tx segmentation
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module async_packet_channel_handler
  import apkt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // avalon-mm slave, byte address
  input wire logic [10:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // ring receive stream
  input wire rx_beat_t net_rx,
  // ring transmit side
  input wire logic net_frame_start,
  input wire logic net_async_slot,
  input wire logic net_grant,
  output logic net_arb_req,
  output logic [7:0] net_priority,
  output tx_beat_t net_tx,
  // interrupt pin
  output logic async_packet_irq_n
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] rx_packet_buffer [RX_BYTES];
  logic [7:0] tx_packet_buffer [TX_BYTES];
  logic [7:0] node_hi_r, node_lo_r, alt_hi_r, alt_lo_r;
  logic [7:0] async_bandwidth_setting;
  logic [7:0] tx_length_quadlets, prio_r;
  logic [4:0] packet_control_reg; // pending one-shot commands
  logic [4:0] packet_status_reg;
  logic tx_start_cmd;
  logic wait_r;
  logic [31:0] rdata_r;
  tx_state_t tx_state_r;
  logic [5:0] tx_idx_r;
  logic [7:0] bw_used_r;
  logic arb_r, irq_n_r;
  tx_beat_t tx_r;
  logic [5:0] rx_idx_r;
  logic [15:0] rx_tgt_r;
  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire [8:0] idx = avs_address[10:2];
  wire req = avs_read | avs_write;
  wire wr_go = avs_write & ~wait_r; // write commits on the ack edge
  wire [7:0] wd = avs_writedata[7:0];
  wire in_rxb = idx >= IDX_RXBUF && idx < IDX_RXBUF + 9'(RX_BYTES);
  wire in_txb = idx >= IDX_TXBUF && idx < IDX_TXBUF + 9'(TX_BYTES);
  wire [5:0] rxb_i = 6'(idx - IDX_RXBUF);
  wire [5:0] txb_i = 6'(idx - IDX_TXBUF);
  wire rx_locked = packet_status_reg[B_RX_RELEASE_CMD];
  // ----------------------------------------------------------------
  // read mux; the buffer carries no length field at all
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00; // unmapped reads as zero
    case (idx)
      IDX_CTRL: rd_byte = {3'b000, packet_control_reg};
      IDX_STAT: rd_byte = {3'b000, packet_status_reg};
      IDX_NODE_HI: rd_byte = node_hi_r;
      IDX_NODE_LO: rd_byte = node_lo_r;
      IDX_BW: rd_byte = async_bandwidth_setting;
      IDX_ALT_HI: rd_byte = alt_hi_r;
      IDX_ALT_LO: rd_byte = alt_lo_r;
      IDX_START: rd_byte = {tx_start_cmd, 7'h00};
      IDX_LEN: rd_byte = tx_length_quadlets;
      IDX_PRIO: rd_byte = prio_r;
      default: begin
        if (in_rxb) rd_byte = rx_packet_buffer[rxb_i];
        else if (in_txb) rd_byte = tx_packet_buffer[txb_i];
      end
    endcase
  end
  // one wait state per access, then a single ack cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= ~(req & wait_r);
      if (req & wait_r) rdata_r <= {24'h00_0000, rd_byte};
    end
  end
  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      node_hi_r <= RST_NODE_HI;
      node_lo_r <= RST_NODE_LO;
      alt_hi_r <= RST_ALT_HI;
      alt_lo_r <= RST_ALT_LO;
      async_bandwidth_setting <= RST_BW;
      tx_length_quadlets <= 8'h00;
      prio_r <= RST_PRIO;
    end else if (wr_go) begin
      case (idx)
        IDX_NODE_HI: node_hi_r <= wd;
        IDX_NODE_LO: node_lo_r <= wd;
        IDX_BW: async_bandwidth_setting <= wd;
        IDX_ALT_HI: alt_hi_r <= wd;
        IDX_ALT_LO: alt_lo_r <= wd;
        IDX_LEN: tx_length_quadlets <= wd;
        IDX_PRIO: prio_r <= wd;
        default: ;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  wire [15:0] rx_tgt_now = (rx_idx_r == 6'd1) ?
                           {rx_tgt_r[15:8], net_rx.data} : rx_tgt_r;
  wire rx_addr_ok = rx_tgt_now == {node_hi_r, node_lo_r} ||
                    rx_tgt_now == {alt_hi_r, alt_lo_r};
  wire rx_end = net_rx.valid & net_rx.eop & rx_addr_ok;
  wire set_arx = rx_end & ~rx_locked & net_rx.crc_ok;
  wire set_af = rx_end & rx_locked;
  wire set_ac = rx_end & ~rx_locked & ~net_rx.crc_ok;
  wire [5:0] rx_wi = net_rx.sop ? 6'd0 : rx_idx_r;
  // byte position tracking and target capture
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_idx_r <= 6'd0;
      rx_tgt_r <= 16'h0000;
    end else if (net_rx.valid) begin
      if (rx_wi < 6'(RX_BYTES)) rx_idx_r <= rx_wi + 6'd1;
      if (rx_wi == 6'd0) rx_tgt_r[15:8] <= net_rx.data;
      if (rx_wi == 6'd1) rx_tgt_r[7:0] <= net_rx.data;
    end
  end
  // ----------------------------------------------------------------
  // buffers as flip-flops, one generate entry per byte
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < RX_BYTES; g++) begin : g_rxb
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) rx_packet_buffer[g] <= 8'h00;
        else if (net_rx.valid && !rx_locked && rx_wi == 6'(g))
          rx_packet_buffer[g] <= net_rx.data;
      end
    end
    for (g = 0; g < TX_BYTES; g++) begin : g_txb
      localparam logic [7:0] RV = (g == 0) ? RST_TGT_HI :
                                  (g == 1) ? RST_TGT_LO : 8'h00;
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) tx_packet_buffer[g] <= RV;
        else if (wr_go && in_txb && txb_i == 6'(g))
          tx_packet_buffer[g] <= wd;
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  // a bad length is pinned into the legal range
  wire [7:0] len_c = (tx_length_quadlets < LEN_MIN) ? LEN_MIN :
                     (tx_length_quadlets > LEN_MAX) ? LEN_MAX :
                     tx_length_quadlets;
  wire [5:0] tx_last = 6'({len_c[3:0], 2'b01}); // 4*len + 1
  wire bw_room = net_frame_start ? (async_bandwidth_setting != 8'h00)
                                 : (bw_used_r < async_bandwidth_setting);
  wire tx_go = (tx_state_r == TX_SEND) & net_async_slot & bw_room;
  wire tx_fin = tx_go & (tx_idx_r == tx_last);
  wire [5:0] tx_bi = (tx_idx_r < 6'd2) ? tx_idx_r : 6'(tx_idx_r - 6'd2);
  wire [7:0] tx_byte = (tx_idx_r == 6'd2) ? node_hi_r :
                       (tx_idx_r == 6'd3) ? node_lo_r :
                       (tx_bi < 6'(TX_BYTES)) ? tx_packet_buffer[tx_bi] : 8'h00;
  // arbitration and per-slot sending; quota resets each frame
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_r <= TX_IDLE;
      tx_idx_r <= 6'd0;
      arb_r <= 1'b0;
      bw_used_r <= 8'h00;
      tx_r <= '0;
    end else begin
      tx_r <= '0;
      if (net_frame_start) bw_used_r <= {7'h00, tx_go};
      else if (tx_go) bw_used_r <= bw_used_r + 8'h01;
      case (tx_state_r)
        TX_IDLE: begin
          tx_idx_r <= 6'd0;
          if (tx_start_cmd) begin
            tx_state_r <= TX_ARB;
            arb_r <= 1'b1;
          end
        end
        TX_ARB: begin
          if (net_grant) begin
            arb_r <= 1'b0;
            tx_state_r <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (tx_go) begin
            tx_r <= '{valid: 1'b1, sop: tx_idx_r == 6'd0,
                      eop: tx_fin, data: tx_byte};
            tx_idx_r <= tx_idx_r + 6'd1;
            if (tx_fin) tx_state_r <= TX_IDLE;
          end
        end
        default: tx_state_r <= TX_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // commands, status flags and interrupt; a flag set beats a clear, a tx_fin clear of the start bit beats a start write
  // ----------------------------------------------------------------
  wire ctrl_wr = wr_go & (idx == IDX_CTRL);
  wire [4:0] clr = packet_control_reg;
  wire [4:0] sets = {set_af, set_ac, 1'b0, tx_fin, set_arx};
  wire [4:0] stat_nxt = (packet_status_reg & ~clr) | sets;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      packet_control_reg <= 5'h00;
      packet_status_reg <= 5'h00;
      tx_start_cmd <= 1'b0;
      irq_n_r <= 1'b1;
    end else begin
      packet_control_reg <= ctrl_wr ? (wd[4:0] & 5'h1B) : 5'h00;
      packet_status_reg <= stat_nxt;
      if (tx_fin) tx_start_cmd <= 1'b0;
      else if (wr_go && idx == IDX_START && wd[B_TX_START_CMD])
        tx_start_cmd <= 1'b1;
      irq_n_r <= ~(stat_nxt[B_TX_DONE_CLEAR_CMD] | stat_nxt[B_RX_RELEASE_CMD]);
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign net_arb_req = arb_r;
  assign net_priority = prio_r;
  assign net_tx = tx_r;
  assign async_packet_irq_n = irq_n_r;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_irq_tx;
    $rose(packet_status_reg[B_TX_DONE_CLEAR_CMD]) |-> !async_packet_irq_n;
  endproperty
  a_irq_tx: assert property (p_irq_tx)
    else $error("tx done without irq");
  property p_irq_rx;
    set_arx |=> rx_locked && !async_packet_irq_n;
  endproperty
  a_irq_rx: assert property (p_irq_rx)
    else $error("rx accept without irq");
  property p_rx_valid;
    $rose(rx_locked) |-> $past(rx_end && net_rx.crc_ok);
  endproperty
  a_rx_valid: assert property (p_rx_valid)
    else $error("rx lock without valid packet");
  property p_slot;
    net_tx.valid |-> $past(net_async_slot && tx_state_r == TX_SEND);
  endproperty
  a_slot: assert property (p_slot)
    else $error("byte sent outside async slot");
  property p_quota;
    !net_frame_start && bw_used_r >= async_bandwidth_setting
      |-> !tx_go;
  endproperty
  a_quota: assert property (p_quota)
    else $error("frame quota exceeded");
  property p_max;
    tx_go |-> tx_idx_r <= 6'd53;
  endproperty
  a_max: assert property (p_max)
    else $error("packet longer than limit");
  property p_start_clr;
    tx_fin |=> !tx_start_cmd && net_tx.eop ##1 tx_state_r == TX_IDLE;
  endproperty
  a_start_clr: assert property (p_start_clr)
    else $error("start bit not released");
  property p_lock;
    rx_locked && net_rx.valid |=> $stable(rx_packet_buffer[0]);
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked buffer overwritten");
  property p_txclr;
    packet_control_reg[B_TX_DONE_CLEAR_CMD] && !tx_fin && !rx_locked && !set_arx
      |=> async_packet_irq_n && !packet_status_reg[B_TX_DONE_CLEAR_CMD];
  endproperty
  a_txclr: assert property (p_txclr)
    else $error("tx done clear ignored");
  property p_full;
    set_af |=> packet_status_reg[B_RAF];
  endproperty
  a_full: assert property (p_full)
    else $error("full reject not flagged");
  property p_hold;
    packet_status_reg[B_TX_DONE_CLEAR_CMD] || packet_status_reg[B_RX_RELEASE_CMD]
      |-> !async_packet_irq_n;
  endproperty
  a_hold: assert property (p_hold)
    else $error("irq released with flag set");
  c_rx_ok: cover property (set_arx);
  c_tx_done: cover property (tx_fin ##1 !async_packet_irq_n);
  c_full: cover property (set_af);
  c_crc: cover property (set_ac);
endmodule : async_packet_channel_handler
`default_nettype wire

// [sim/ring_model.sv]
// ring-side model: frame timing, async byte slots and arbitration grants
`timescale 1ns/1ps
`default_nettype none
module ring_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // grant speed: 0 prompt, 1 slow
  input wire logic slow,
  // device side
  input wire logic net_arb_req,
  output logic net_frame_start,
  output logic net_async_slot,
  output logic net_grant
);
  logic [4:0] pos_r; // position in the 20-cycle frame
  logic [3:0] wait_r; // cycles the request has waited
  logic [3:0] dly; // grant delay for this speed
  assign dly = slow ? 4'h7 : 4'h1;
  // twelve slots a frame, more than any quota used, so the device must skip
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pos_r <= 5'h00;
      wait_r <= 4'h0;
      net_frame_start <= 1'b0;
      net_async_slot <= 1'b0;
      net_grant <= 1'b0;
    end else begin
      pos_r <= (pos_r == 5'h13) ? 5'h00 : pos_r + 5'h01;
      net_frame_start <= (pos_r == 5'h00);
      net_async_slot <= (pos_r >= 5'h01) && (pos_r <= 5'h0C);
      // wins arbitration after a fixed wait; one pulse per request
      wait_r <= net_arb_req ? wait_r + 4'h1 : 4'h0;
      net_grant <= net_arb_req && (wait_r == dly);
    end
  end
endmodule : ring_model
`default_nettype wire

// [sim/async_packet_channel_handler_tb.sv]
// self-checking bench of the packet channel handler
`timescale 1ns/1ps
`default_nettype none
module async_packet_channel_handler_tb;
  import apkt_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk, reset_n, avs_read, avs_write, avs_waitrequest, slow;
  logic [10:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  rx_beat_t net_rx;
  tx_beat_t net_tx;
  logic fs, slot, grant, arb_req, irq_n;
  logic [7:0] prio;
  int n_fail, checks_done, seed, fcnt, bw;
  logic fs_q, slot_q; // previous-cycle frame start and slot
  logic [7:0] txq[$]; // bytes seen on the ring
  logic [7:0] txb[TX_BYTES]; // tx buffer image
  logic [7:0] rxp[RX_BYTES]; // last accepted packet
  logic [7:0] node_hi, node_lo, rd;
  logic rx_busy; // rx buffer locked, image must not follow the link
  // ----------------------------------------------------------------
  // design and ring model
  // ----------------------------------------------------------------
  async_packet_channel_handler u_dut (.clk(clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .net_rx(net_rx), .net_frame_start(fs), .net_async_slot(slot),
    .net_grant(grant), .net_arb_req(arb_req), .net_priority(prio),
    .net_tx(net_tx), .async_packet_irq_n(irq_n));
  ring_model u_ring (.clk(clk), .reset_n(reset_n), .slow(slow),
    .net_arb_req(arb_req), .net_frame_start(fs),
    .net_async_slot(slot), .net_grant(grant));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // compare and close
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task complete_run;
    $display("fails %0d checks %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // watchdog sized well above the longest run
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    complete_run;
  end
  // ----------------------------------------------------------------
  // ring monitor, sampled mid-cycle where outputs are settled
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (fs_q) fcnt = 0;
    if (net_tx.valid === 1'b1) begin
      txq.push_back(net_tx.data);
      fcnt++;
      chk("byte in slot", 1, slot_q);
      if (fcnt > bw) chk("frame quota", bw, fcnt);
    end
    fs_q = fs;
    slot_q = slot;
  end
  // ----------------------------------------------------------------
  // avalon master: held until waitrequest low at a rising edge
  // ----------------------------------------------------------------
  task bus(input logic wr, input logic [8:0] i, input logic [7:0] d);
    @(posedge clk);
    avs_address <= {i, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h000000, d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task rchk(input string nm, input logic [8:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    chk(nm, e, rd);
  endtask : rchk
  // one rx packet; byte 0/1 target, then source and payload
  task send_rx(input logic [7:0] th, tl, input logic ok, input int n);
    logic [7:0] b;
    for (int k = 0; k < n; k++) begin
      b = (k == 0) ? th : (k == 1) ? tl : 8'($random(seed));
      if (k < RX_BYTES && !rx_busy) rxp[k] = b;
      @(posedge clk);
      net_rx <= '{1'b1, k == 0, k == n - 1, ok, b};
    end
    @(posedge clk);
    net_rx <= '{1'b0, 1'b0, 1'b0, 1'b0, ~b};
    repeat (3) @(posedge clk);
  endtask : send_rx
  task wait_irq;
    for (int t = 0; t < 4000 && irq_n !== 1'b0; t++) @(negedge clk);
    // let the ring monitor take the last byte first
    @(posedge clk);
  endtask : wait_irq
  // expected ring byte k: target, own address, data, zero filler
  function automatic logic [7:0] exp_tx(input int k);
    if (k == 2) return node_hi;
    if (k == 3) return node_lo;
    if (k < 2) return txb[k];
    if (k - 2 < TX_BYTES) return txb[k - 2];
    return 8'h00;
  endfunction : exp_tx
  // loads a packet of len quadlets and sends it
  task run_tx(input logic [7:0] len);
    logic [7:0] p;
    p = 8'(1 + $unsigned($random(seed)) % 7);
    bw = 2 + $unsigned($random(seed)) % 5;
    bus(1'b1, IDX_BW, 8'(bw));
    bus(1'b1, IDX_PRIO, p);
    bus(1'b1, IDX_LEN, len);
    for (int k = 0; k < 4 * len && k < TX_BYTES; k++) begin
      txb[k] = 8'($random(seed));
      bus(1'b1, IDX_TXBUF + 9'(k), txb[k]);
    end
    txq.delete();
    bus(1'b1, IDX_START, 8'h80);
    chk("priority", p, prio);
    wait_irq;
    chk("tx irq", 0, irq_n);
    chk("tx count", 4 * len + 2, txq.size());
    for (int k = 0; k < txq.size(); k++)
      chk("tx byte", exp_tx(k), txq[k]);
    rchk("start clr", IDX_START, 8'h00);
    rchk("tx status", IDX_STAT, 8'h02);
  endtask : run_tx
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 59170;
    n_fail = 0;
    checks_done = 0;
    fcnt = 0;
    bw = 0;
    reset_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 11'h000;
    avs_writedata = 32'h00000000;
    net_rx = '0;
    slow = 1'b0;
    rx_busy = 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    chk("irq reset", 1, irq_n);
    rchk("alt lo", IDX_ALT_LO, RST_ALT_LO);
    rchk("prio", IDX_PRIO, RST_PRIO);
    rchk("txbuf 0", IDX_TXBUF, RST_TGT_HI);
    rchk("txbuf 1", IDX_TXBUF + 9'h001, RST_TGT_LO);
    bus(1'b1, 9'h0F8, 8'h5A);
    rchk("unmapped", 9'h0F8, 8'h00);
    node_hi = 8'($random(seed));
    node_lo = 8'($random(seed));
    bus(1'b1, IDX_NODE_HI, node_hi);
    bus(1'b1, IDX_NODE_LO, node_lo);
    // transmit corner lengths then random ones, prompt and slow grants
    for (int i = 0; i < 5; i++) begin
      slow = i[0];
      run_tx(i == 0 ? LEN_MIN : i == 1 ? LEN_MAX :
             8'(1 + $unsigned($random(seed)) % 13));
      rchk("ctrl idle", IDX_CTRL, 8'h00);
      bus(1'b1, IDX_CTRL, 8'h02);
      repeat (2) @(posedge clk);
      chk("irq off", 1, irq_n);
    end
    // good packet to the node address, longest size
    send_rx(node_hi, node_lo, 1'b1, RX_BYTES);
    chk("rx irq", 0, irq_n);
    rchk("rx status", IDX_STAT, 8'h01);
    rx_busy = 1'b1;
    // second packet while locked is refused
    send_rx(node_hi, node_lo, 1'b1, 8);
    rchk("full flag", IDX_STAT, 8'h11);
    for (int k = 0; k < RX_BYTES; k++) begin
      bus(1'b0, IDX_RXBUF + 9'(k), 8'h00);
      chk("rx byte", rxp[k], rd);
    end
    bus(1'b1, IDX_CTRL, 8'h11);
    rx_busy = 1'b0;
    repeat (2) @(posedge clk);
    chk("irq rel", 1, irq_n);
    rchk("clr status", IDX_STAT, 8'h00);
    // bad crc, wrong target, then the alternate address
    send_rx(node_hi, node_lo, 1'b0, 4 + $unsigned($random(seed)) % 17);
    chk("crc no irq", 1, irq_n);
    rchk("crc flag", IDX_STAT, 8'h08);
    bus(1'b1, IDX_CTRL, 8'h08);
    send_rx(~node_hi, node_lo, 1'b1, 10);
    rchk("wrong tgt", IDX_STAT, 8'h00);
    // both done flags: irq stays low until both cleared
    run_tx(8'h03);
    send_rx(RST_ALT_HI, RST_ALT_LO, 1'b1, 12);
    rchk("both", IDX_STAT, 8'h03);
    bus(1'b1, IDX_CTRL, 8'h02);
    repeat (2) @(posedge clk);
    chk("irq held", 0, irq_n);
    bus(1'b1, IDX_CTRL, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq idle", 1, irq_n);
    complete_run;
  end
endmodule : async_packet_channel_handler_tb
`default_nettype wire
